// ==== gpio_shared_pkg.sv ====
// Purpose: Shared constants for the shared-pin port block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Register indices are word indices; the byte address is four times the index.
package gpio_shared_pkg;
  // Register word indices.
  localparam logic [9:0] IDX_PORT_D_DATA = 10'h003;
  localparam logic [9:0] IDX_PORT_D_DIR = 10'h007;
  localparam logic [9:0] IDX_PORT_E_DATA = 10'h008;
  localparam logic [9:0] IDX_PORT_F_DATA = 10'h009;
  localparam logic [9:0] IDX_PORT_E_DIR = 10'h00c;
  localparam logic [9:0] IDX_PORT_F_DIR = 10'h00d;
  // Values after reset.
  localparam logic [7:0] DIR_RESET_8 = 8'h00;
  localparam logic [6:0] DIR_RESET_7 = 7'h00;
  localparam logic [7:0] OE_N_RESET_8 = 8'hff;
  localparam logic [6:0] OE_N_RESET_7 = 7'h7f;
  // Prescaler code that selects the external timer clock pin.
  localparam logic [2:0] EXT_CLOCK_CODE = 3'h7;
  // Bit positions of shared pins.
  localparam int PD_TIMER_B_CLK = 4;
  localparam int PD_TIMER_A_CLK = 6;
  localparam int PE_SPI_CLK = 7;
  localparam int PE_SPI_MOSI = 6;
  localparam int PE_SPI_MISO = 5;
  localparam int PE_SPI_SEL = 4;
  localparam int PE_SERIAL_RX = 1;
  localparam int PE_SERIAL_TX = 0;
  // First converter channel number that lands on port D bit 0.
  localparam logic [4:0] ADC_PORT_D_BASE = 5'h08;
endpackage

// ==== pin_sync.sv ====
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to pclk.
// Notes: The first stage is read only by the second stage.
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Both stages clear on reset so reads start from a defined level.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // pin_sync

// ==== shared_pin_io_ports.sv ====
// Purpose: Ports D, E and F with data latches, direction bits and peripheral pin sharing.
// Assumes: Peripheral controls come from logic on pclk; pins are asynchronous.
// Notes: Pin outputs and enables are registered, so a change reaches the pins one cycle late.
//   Owned pins ignore direction for drive, but direction still steers the read mux.
// Functional notes
// - Timer-owned port D pin ignores direction for drive; direction picks latch or zero.
// - External prescaler choice hands timer clock pins to timers; otherwise ordinary I/O.
// - Port D direction one enables the output buffer, zero makes an input.
// - Reset clears all port D direction bits.
// - Port D read gives latch for outputs, pin level for inputs.
// - Data writes always update the latch; inputs still read the pin.
// - Port E bit 7 is SPI clock, out as master, in as slave, when enabled.
// - Port E bits 6 and 5 are SPI data pins while SPI is enabled.
// - Port E bit 4 is ordinary I/O unless SPI is enabled as slave or with fault detection on.
// - Peripheral-owned port E pins ignore direction for drive; direction still picks read.
// - Port E bits 3 and 2 follow timer channel edge/level select.
// - Port E bits 1 and 0 are serial receive and transmit while serial enabled.
// - Reset clears all port E direction bits.
// - Port E read gives latch for outputs, pin level for inputs.
// - Port F has seven bits with latch and direction; reset keeps its latches.
// - Port F bits 3 to 0 follow timer channel edge/level select.
// - Port D converter channel reads zero as input, latch otherwise.
//
// The APB interface to the registers was left to the implementer.
module shared_pin_io_ports
  import gpio_shared_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe_n,
  input wire logic [7:0] port_e_in,
  output logic [7:0] port_e_out,
  output logic [7:0] port_e_oe_n,
  input wire logic [6:0] port_f_in,
  output logic [6:0] port_f_out,
  output logic [6:0] port_f_oe_n,
  input wire logic [2:0] timer_a_prescaler_select,
  input wire logic [2:0] timer_b_prescaler_select,
  input wire logic adc_enable,
  input wire logic [4:0] adc_channel_select,
  input wire logic spi_module_enable,
  input wire logic spi_master_select,
  input wire logic mode_fault_enable,
  input wire logic spi_clock_out,
  input wire logic spi_mosi_out,
  input wire logic spi_miso_out,
  input wire logic serial_interface_enable,
  input wire logic serial_tx_out,
  input wire logic [11:0] timer_a_edge_level_select,
  input wire logic [5:0] timer_a_channel_compare,
  input wire logic [5:0] timer_a_channel_out,
  output logic [7:0] port_d_pin_level,
  output logic [7:0] port_e_pin_level,
  output logic [6:0] port_f_pin_level
);
  // Pin levels after the two-flop crossing, and the copies handed to peripherals.
  logic [7:0] pd_sync;
  logic [7:0] pe_sync;
  logic [6:0] pf_sync;
  logic [7:0] pd_lvl_q;
  logic [7:0] pe_lvl_q;
  logic [6:0] pf_lvl_q;

  // Data latches, direction bits and registered bus answers.
  logic [7:0] pd_data_q, pd_data_d;
  logic [7:0] pe_data_q, pe_data_d;
  logic [6:0] pf_data_q, pf_data_d;
  logic [7:0] pd_dir_q, pd_dir_d;
  logic [7:0] pe_dir_q, pe_dir_d;
  logic [6:0] pf_dir_q, pf_dir_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  // Registered pin drive, so the pins never see the decode settling.
  logic [7:0] pd_out_q, pd_out_d, pd_oe_n_q, pd_oe_n_d;
  logic [7:0] pe_out_q, pe_out_d, pe_oe_n_q, pe_oe_n_d;
  logic [6:0] pf_out_q, pf_out_d, pf_oe_n_q, pf_oe_n_d;

  // Per-pin ownership masks and the read views built from them.
  logic [7:0] pd_timer_own;
  logic [7:0] pd_adc_own;
  logic [7:0] pd_read;
  logic [7:0] pe_read;
  logic [6:0] pf_read;
  logic [5:0] chan_own;

  // Bus decode for the transfer now on the bus.
  logic [9:0] idx;
  logic setup_phase;
  logic write_now;
  logic addr_ok;

  // Decodes a word index into a mapped flag.
  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = (i == IDX_PORT_D_DATA) || (i == IDX_PORT_D_DIR) ||
                (i == IDX_PORT_E_DATA) || (i == IDX_PORT_E_DIR) ||
                (i == IDX_PORT_F_DATA) || (i == IDX_PORT_F_DIR);
  endfunction

  // Read mux shared by every port: latch for outputs, pin otherwise.
  // Port F passes through it zero-extended to eight bits.
  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pin);
    port_view = (dir & latch) | (~dir & pin);
  endfunction

  // Pins cross into pclk through two flops before any logic reads them.
  // Reset clears the synchronisers, so reads right after reset show low pins.
  pin_sync #(.WIDTH(8)) u_sync_d (.pclk(pclk), .presetn(presetn), .async_in(port_d_in),
                                  .sync_out(pd_sync));
  pin_sync #(.WIDTH(8)) u_sync_e (.pclk(pclk), .presetn(presetn), .async_in(port_e_in),
                                  .sync_out(pe_sync));
  pin_sync #(.WIDTH(7)) u_sync_f (.pclk(pclk), .presetn(presetn), .async_in(port_f_in),
                                  .sync_out(pf_sync));

  // Timer channels claim a pin whenever either edge/level select bit is set.
  // Channels zero and one land on port E, channels two to five on port F.
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_chan_own
      assign chan_own[g] = |timer_a_edge_level_select[2*g+1:2*g];
    end
    // Converter channels eight to fourteen sit on port D bits zero to six.
    for (g = 0; g < 8; g++)
    begin : g_adc
      if (g < 7)
      begin : g_on_port
        assign pd_adc_own[g] = adc_enable && (adc_channel_select == ADC_PORT_D_BASE + 5'(g));
      end
      else
      begin : g_none
        assign pd_adc_own[g] = 1'b0;
      end
    end
  endgenerate

  // Timer clock pins leave the port only on the external prescaler code.
  // Every other code leaves the pin as ordinary I/O under its direction bit.
  always_comb
  begin
    pd_timer_own = 8'h00;
    pd_timer_own[PD_TIMER_A_CLK] = (timer_a_prescaler_select == EXT_CLOCK_CODE);
    pd_timer_own[PD_TIMER_B_CLK] = (timer_b_prescaler_select == EXT_CLOCK_CODE);
  end

  // Read views; owned port D pins read zero rather than the pin when input.
  always_comb
  begin
    pd_read = port_view(pd_dir_q, pd_data_q, pd_sync);
    pd_read = pd_read & ~(~pd_dir_q & (pd_timer_own | pd_adc_own));
    pe_read = port_view(pe_dir_q, pe_data_q, pe_sync);
    pf_read = 7'(port_view({1'b0, pf_dir_q}, {1'b0, pf_data_q}, {1'b0, pf_sync}));
  end

  assign idx = paddr[11:2];
  assign addr_ok = is_mapped(idx) && (paddr[1:0] == 2'b00);
  assign setup_phase = psel && !penable;
  assign write_now = psel && penable && pready_q && pwrite && addr_ok && pstrb[0];

  // Register writes; data latches take every write whatever the direction bits.
  // A write with the low byte strobe clear is dropped, as is any refused access.
  always_comb
  begin
    pd_data_d = pd_data_q;
    pe_data_d = pe_data_q;
    pf_data_d = pf_data_q;
    pd_dir_d = pd_dir_q;
    pe_dir_d = pe_dir_q;
    pf_dir_d = pf_dir_q;
    if (write_now)
    begin
      unique case (idx)
        IDX_PORT_D_DATA: pd_data_d = pwdata[7:0];
        IDX_PORT_E_DATA: pe_data_d = pwdata[7:0];
        IDX_PORT_F_DATA: pf_data_d = pwdata[6:0];
        IDX_PORT_D_DIR: pd_dir_d = pwdata[7:0];
        IDX_PORT_E_DIR: pe_dir_d = pwdata[7:0];
        IDX_PORT_F_DIR: pf_dir_d = pwdata[6:0];
        default: pd_data_d = pd_data_q;
      endcase
    end
  end

  // Zero-wait slave: read data are captured in setup and ready rises in the access cycle.
  // A pin change during the access cycle is therefore seen only by the next read.
  always_comb
  begin
    pready_d = setup_phase;
    pslverr_d = setup_phase && !addr_ok;
    prdata_d = prdata_q;
    if (setup_phase)
    begin
      prdata_d = 32'h0000_0000;
      if (!pwrite && addr_ok)
      begin
        unique case (idx)
          IDX_PORT_D_DATA: prdata_d[7:0] = pd_read;
          IDX_PORT_E_DATA: prdata_d[7:0] = pe_read;
          IDX_PORT_F_DATA: prdata_d[6:0] = pf_read;
          IDX_PORT_D_DIR: prdata_d[7:0] = pd_dir_q;
          IDX_PORT_E_DIR: prdata_d[7:0] = pe_dir_q;
          IDX_PORT_F_DIR: prdata_d[6:0] = pf_dir_q;
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // Port D drive: owned pins are released, the rest follow latch and direction.
  // Timer clock and converter pins are inputs only, so ownership simply releases them.
  always_comb
  begin
    pd_out_d = pd_data_q;
    pd_oe_n_d = ~pd_dir_q | pd_timer_own | pd_adc_own;
  end

  // Port E drive: the SPI, timer and serial modules override direction bits.
  // The owners never share a bit, so the order of the branches below does not matter.
  always_comb
  begin
    pe_out_d = pe_data_q;
    pe_oe_n_d = ~pe_dir_q;
    if (spi_module_enable)
    begin
      // Clock and MOSI are driven by a master and listened to by a slave.
      pe_out_d[PE_SPI_CLK] = spi_clock_out;
      pe_oe_n_d[PE_SPI_CLK] = !spi_master_select;
      pe_out_d[PE_SPI_MOSI] = spi_mosi_out;
      pe_oe_n_d[PE_SPI_MOSI] = !spi_master_select;
      pe_out_d[PE_SPI_MISO] = spi_miso_out;
      pe_oe_n_d[PE_SPI_MISO] = spi_master_select;
      // Slave select stays ordinary I/O for a master without fault detection.
      if (!spi_master_select || mode_fault_enable)
      begin
        pe_oe_n_d[PE_SPI_SEL] = 1'b1;
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      if (chan_own[i])
      begin
        pe_out_d[2+i] = timer_a_channel_out[i];
        pe_oe_n_d[2+i] = !timer_a_channel_compare[i];
      end
    end
    if (serial_interface_enable)
    begin
      pe_oe_n_d[PE_SERIAL_RX] = 1'b1;
      pe_out_d[PE_SERIAL_TX] = serial_tx_out;
      pe_oe_n_d[PE_SERIAL_TX] = 1'b0;
    end
  end

  // Port F drive: timer channels two to five claim bits zero to three.
  // Bits six to four have no sharing here and follow latch and direction only.
  always_comb
  begin
    pf_out_d = pf_data_q;
    pf_oe_n_d = ~pf_dir_q;
    for (int i = 0; i < 4; i++)
    begin
      if (chan_own[2+i])
      begin
        pf_out_d[i] = timer_a_channel_out[2+i];
        pf_oe_n_d[i] = !timer_a_channel_compare[2+i];
      end
    end
  end

  // Data latches have no reset, so a latch keeps its value across reset.
  // This trades a known start value for keeping software's pattern through a reset.
  always_ff @(posedge pclk)
  begin
    pd_data_q <= pd_data_d;
    pe_data_q <= pe_data_d;
    pf_data_q <= pf_data_d;
  end

  // Control, bus and pin-drive state; reset releases every pin.
  // Pin levels pass one more flop so peripherals see a copy that changes on pclk only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pd_dir_q <= DIR_RESET_8;
      pe_dir_q <= DIR_RESET_8;
      pf_dir_q <= DIR_RESET_7;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      pd_out_q <= 8'h00;
      pe_out_q <= 8'h00;
      pf_out_q <= 7'h00;
      pd_oe_n_q <= OE_N_RESET_8;
      pe_oe_n_q <= OE_N_RESET_8;
      pf_oe_n_q <= OE_N_RESET_7;
      pd_lvl_q <= 8'h00;
      pe_lvl_q <= 8'h00;
      pf_lvl_q <= 7'h00;
    end
    else
    begin
      pd_dir_q <= pd_dir_d;
      pe_dir_q <= pe_dir_d;
      pf_dir_q <= pf_dir_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      pd_out_q <= pd_out_d;
      pe_out_q <= pe_out_d;
      pf_out_q <= pf_out_d;
      pd_oe_n_q <= pd_oe_n_d;
      pe_oe_n_q <= pe_oe_n_d;
      pf_oe_n_q <= pf_oe_n_d;
      pd_lvl_q <= pd_sync;
      pe_lvl_q <= pe_sync;
      pf_lvl_q <= pf_sync;
    end
  end

  // Every output comes straight from a register.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign port_d_out = pd_out_q;
  assign port_d_oe_n = pd_oe_n_q;
  assign port_e_out = pe_out_q;
  assign port_e_oe_n = pe_oe_n_q;
  assign port_f_out = pf_out_q;
  assign port_f_oe_n = pf_oe_n_q;
  assign port_d_pin_level = pd_lvl_q;
  assign port_e_pin_level = pe_lvl_q;
  assign port_f_pin_level = pf_lvl_q;
endmodule // shared_pin_io_ports

// ==== pin_world.sv ====
// Purpose: Outside world of the port pins: the block's drivers plus external drivers.
// Assumes: External drivers are stiff; no contention model.
// Notes: An undriven pin shows the bench's external level, never the block's last value.
module pin_world (
  input wire logic [7:0] port_d_out,
  input wire logic [7:0] port_d_oe_n,
  input wire logic [7:0] ext_d,
  input wire logic [7:0] port_e_out,
  input wire logic [7:0] port_e_oe_n,
  input wire logic [7:0] ext_e,
  input wire logic [6:0] port_f_out,
  input wire logic [6:0] port_f_oe_n,
  input wire logic [6:0] ext_f,
  output logic [7:0] port_d_in,
  output logic [7:0] port_e_in,
  output logic [6:0] port_f_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // A pin whose enable is low shows the block's value; otherwise the outside level.
  assign port_d_in = (port_d_out & ~port_d_oe_n) | (ext_d & port_d_oe_n);
  assign port_e_in = (port_e_out & ~port_e_oe_n) | (ext_e & port_e_oe_n);
  assign port_f_in = (port_f_out & ~port_f_oe_n) | (ext_f & port_f_oe_n);
endmodule // pin_world

// ==== gpio_port_monitor.sv ====
// Purpose: Port-level checks for the shared-pin port block.
// Assumes: One pclk domain; peripheral controls are on pclk.
// Notes: Pin drive is registered, so drive checks look one edge on.
module gpio_port_monitor
  import gpio_shared_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] port_d_oe_n,
  input wire logic [7:0] port_e_oe_n,
  input wire logic [7:0] port_e_out,
  input wire logic [2:0] timer_a_prescaler_select,
  input wire logic [2:0] timer_b_prescaler_select,
  input wire logic spi_module_enable,
  input wire logic spi_master_select,
  input wire logic spi_clock_out,
  input wire logic serial_interface_enable,
  input wire logic serial_tx_out,
  input wire logic [11:0] timer_a_edge_level_select,
  input wire logic [5:0] timer_a_channel_compare,
  input wire logic [5:0] timer_a_channel_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // All checks share one clock and one reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_misalign: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("misaligned access not refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reset_inputs: assert property ($rose(presetn) |-> &port_d_oe_n && &port_e_oe_n)
    else $error("pins driven right after reset");
  a_tclk_undriven: assert property (timer_a_prescaler_select == EXT_CLOCK_CODE
    && timer_b_prescaler_select == EXT_CLOCK_CODE |=> port_d_oe_n[6] && port_d_oe_n[4])
    else $error("timer clock pin driven");
  a_spi_master: assert property (spi_module_enable && spi_master_select
    |=> !port_e_oe_n[7] && port_e_out[7] == $past(spi_clock_out))
    else $error("spi clock not driven as master");
  a_spi_slave: assert property (spi_module_enable && !spi_master_select
    |=> port_e_oe_n[7] && port_e_oe_n[6] && !port_e_oe_n[5] && port_e_oe_n[4])
    else $error("spi slave pin drive wrong");
  a_serial_pins: assert property (serial_interface_enable
    |=> port_e_oe_n[1] && !port_e_oe_n[0] && port_e_out[0] == $past(serial_tx_out))
    else $error("serial pin drive wrong");
  a_tch_drive: assert property (timer_a_edge_level_select[1:0] != 2'h0
    && timer_a_channel_compare[0] |=> !port_e_oe_n[2]
    && port_e_out[2] == $past(timer_a_channel_out[0]))
    else $error("timer channel pin drive wrong");
endmodule // gpio_port_monitor

bind shared_pin_io_ports gpio_port_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .port_d_oe_n, .port_e_oe_n, .port_e_out, .timer_a_prescaler_select,
  .timer_b_prescaler_select, .spi_module_enable, .spi_master_select, .spi_clock_out,
  .serial_interface_enable, .serial_tx_out, .timer_a_edge_level_select,
  .timer_a_channel_compare, .timer_a_channel_out);

// ==== shared_pin_io_ports_test.sv ====
// Purpose: Register-level tests of the shared-pin port block.
// Assumes: APB slave answers whenever it is ready; pins reach read data through two flops.
// Notes: Waits of six cycles cover drive plus synchroniser latency.
module shared_pin_io_ports_test
  import gpio_shared_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, er;
  logic [7:0] port_d_in, port_d_out, port_d_oe_n, port_e_in, port_e_out, port_e_oe_n;
  logic [6:0] port_f_in, port_f_out, port_f_oe_n;
  logic [7:0] ext_d = 8'h7f, ext_e = 8'h96, port_d_pin_level, port_e_pin_level;
  logic [6:0] ext_f = 7'h2a, port_f_pin_level;
  logic [2:0] timer_a_prescaler_select = 3'h0, timer_b_prescaler_select = 3'h0;
  logic adc_enable = 1'b0, spi_module_enable = 1'b0, spi_master_select = 1'b0;
  logic mode_fault_enable = 1'b0, spi_clock_out = 1'b1, spi_mosi_out = 1'b0;
  logic spi_miso_out = 1'b1, serial_interface_enable = 1'b0, serial_tx_out = 1'b0;
  logic [4:0] adc_channel_select = 5'h00;
  logic [11:0] timer_a_edge_level_select = 12'h000;
  logic [5:0] timer_a_channel_compare = 6'h00, timer_a_channel_out = 6'h3b;
  logic [9:0] mode_ctl [5] = '{10'h000, 10'h300, 10'h200, 10'h065, 10'h380};
  logic [7:0] mode_oe [5] = '{8'h0f, 8'h2f, 8'hdf, 8'h0a, 8'h3f};
  int errors = 0, checks_done = 0;

  // Free-running bus clock.
  always #2 pclk = ~pclk;

  shared_pin_io_ports u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .port_d_in, .port_d_out, .port_d_oe_n, .port_e_in, .port_e_out,
    .port_e_oe_n, .port_f_in, .port_f_out, .port_f_oe_n, .timer_a_prescaler_select,
    .timer_b_prescaler_select, .adc_enable, .adc_channel_select, .spi_module_enable,
    .spi_master_select, .mode_fault_enable, .spi_clock_out, .spi_mosi_out, .spi_miso_out,
    .serial_interface_enable, .serial_tx_out, .timer_a_edge_level_select,
    .timer_a_channel_compare, .timer_a_channel_out, .port_d_pin_level, .port_e_pin_level,
    .port_f_pin_level);

  pin_world u_pins (.port_d_out, .port_d_oe_n, .ext_d, .port_e_out, .port_e_oe_n, .ext_e,
    .port_f_out, .port_f_oe_n, .ext_f, .port_d_in, .port_e_in, .port_f_in);

  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'h0};
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  // Only the watchdog ends a wait for an answer that never comes.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd, exp);
  endtask

  // Lets drive and synchroniser settle, then samples mid-cycle.
  task automatic settle();
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic wrap_up();
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard at 10000 cycles, far beyond the hundred and sixty or so cycles the tests use.
  initial
  begin
    #40000;
    errors++;
    wrap_up();
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("oe_n", 32'({port_f_oe_n, port_e_oe_n, port_d_oe_n}), 32'h7fffff);
    chk("pin_level", 32'({port_f_pin_level, port_e_pin_level, port_d_pin_level}), 32'h2a967f);
    rdc(ad(IDX_PORT_D_DIR), 32'h0);
    rdc(ad(IDX_PORT_E_DIR), 32'h0);
    apb(1'b1, ad(IDX_PORT_D_DATA), 32'hc3);
    settle();
    rdc(ad(IDX_PORT_D_DATA), 32'h7f);
    apb(1'b1, ad(IDX_PORT_D_DIR), 32'hff);
    settle();
    chk("port_d", 32'({port_d_oe_n, port_d_out}), 32'h00c3);
    rdc(ad(IDX_PORT_D_DATA), 32'hc3);
    // Hand bits 6 and 4 to the timers and bit 0 to the converter.
    timer_a_prescaler_select <= EXT_CLOCK_CODE;
    timer_b_prescaler_select <= EXT_CLOCK_CODE;
    adc_enable <= 1'b1;
    adc_channel_select <= ADC_PORT_D_BASE;
    apb(1'b1, ad(IDX_PORT_D_DIR), 32'hbe);
    settle();
    chk("port_d_oe_n", 32'(port_d_oe_n), 32'h51);
    rdc(ad(IDX_PORT_D_DATA), 32'h82);
    timer_a_prescaler_select <= 3'h0;
    timer_b_prescaler_select <= 3'h0;
    adc_enable <= 1'b0;
    settle();
    chk("port_d_oe_n", 32'(port_d_oe_n), 32'h41);
    rdc(ad(IDX_PORT_D_DATA), 32'hc3);
    apb(1'b1, ad(IDX_PORT_E_DATA), 32'h5c);
    apb(1'b1, ad(IDX_PORT_E_DIR), 32'hf0);
    // Walk the port E sharing modes: off, master, slave, serial and timer, master with fault.
    for (int i = 0; i < 5; i++)
    begin
      @(posedge pclk);
      {spi_module_enable, spi_master_select, mode_fault_enable, serial_interface_enable,
        timer_a_edge_level_select[3:0], timer_a_channel_compare[1:0]} <= mode_ctl[i];
      settle();
      chk("port_e_oe_n", 32'(port_e_oe_n), 32'(mode_oe[i]));
      rdc(ad(IDX_PORT_E_DATA), 32'h56);
    end
    apb(1'b0, 12'h3fc, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h00d, 32'h00);
    chk("misaligned", 32'(er), 32'h1);
    rdc(ad(IDX_PORT_D_DATA), 32'hc3);
    // Port F latch must survive a reset in mid-run; channel 2 owns bit 0.
    apb(1'b1, ad(IDX_PORT_F_DATA), 32'h55);
    timer_a_edge_level_select <= 12'h010;
    timer_a_channel_compare <= 6'h04;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("port_f_oe_n", 32'(port_f_oe_n), 32'h7e);
    chk("port_f_out", 32'(port_f_out), 32'h54);
    apb(1'b1, ad(IDX_PORT_F_DIR), 32'h7f);
    rdc(ad(IDX_PORT_F_DATA), 32'h55);
    wrap_up();
  end
endmodule // shared_pin_io_ports_test
